// *** design/ubg_pkg.sv ***
// constants, field layouts and carrier types for the uart baud and fifo interrupt block
// How it works
// - divide input clock by 16-bit divisor
// - divided output is sixteen times baud
// - divisor kept in two byte latches
// - divisor latch write reloads counter at once
// - divisor zero divides by three
// - divisor one inverts the input clock
// - divisor two gives half rate, even duty
// - divisor three up: low two, high rest
// - high-speed codes give 230400 and 460800 baud
// - receive interrupts need enable bit; timeout also needs fifo
// - data-available follows fill against trigger level
// - line status outranks data available
// - data ready while receive fifo non-empty
// - timeout after four idle character times
// - timeout counted in baud-derived character times
// - one read clears active timeout and timer
// - read, or arrival with no timeout pending, restarts idle timer
// - holding-empty interrupt, cleared by write or ident
// - first empty delayed one character minus stop
// - fifo enable change raises transmit interrupt
// - timeout ranks below line status, above data available
package ubg_pkg;
    // fifo geometry
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned PTR_W = 4;
    localparam int unsigned CNT_W = 5;
    localparam logic [CNT_W-1:0] FIFO_FULL = 5'h10;
    // register indices; byte address is four times the index
    localparam logic [2:0] IDX_DATA = 3'h0;
    localparam logic [2:0] IDX_IER = 3'h1;
    localparam logic [2:0] IDX_IIR = 3'h2;
    localparam logic [2:0] IDX_LCR = 3'h3;
    localparam logic [2:0] IDX_LSR = 3'h5;
    localparam logic [2:0] IDX_SCR = 3'h7;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned IDX_MSB = 4;
    // enable register bits
    localparam int unsigned IER_RDA = 0;
    localparam int unsigned IER_THR = 1;
    localparam int unsigned IER_LS = 2;
    // fifo control bits
    localparam int unsigned FCR_EN = 0;
    localparam int unsigned FCR_RXCLR = 1;
    localparam int unsigned FCR_TXCLR = 2;
    localparam int unsigned FCR_TRIG_LSB = 6;
    // line control bits
    localparam int unsigned LCR_STOP = 2;
    localparam int unsigned LCR_PAR = 3;
    localparam int unsigned LCR_DIVISOR_ACCESS_BIT = 7;
    // identification codes
    localparam logic [7:0] IIR_NONE = 8'h01;
    localparam logic [7:0] IIR_LS = 8'h06;
    localparam logic [7:0] IIR_RDA = 8'h04;
    localparam logic [7:0] IIR_TOUT = 8'h0C;
    localparam logic [7:0] IIR_THR = 8'h02;
    localparam logic [7:0] IIR_FIFO_ON = 8'hC0;
    // receive trigger levels
    localparam logic [CNT_W-1:0] TRIG_1 = 5'h01;
    localparam logic [CNT_W-1:0] TRIG_4 = 5'h04;
    localparam logic [CNT_W-1:0] TRIG_8 = 5'h08;
    localparam logic [CNT_W-1:0] TRIG_14 = 5'h0E;
    // baud generator
    localparam logic [15:0] DIV_ZERO_PERIOD = 16'h0003;
    localparam logic [15:0] DIV_HS_X2 = 16'h8002;
    localparam logic [15:0] DIV_HS_X4 = 16'h8001;
    localparam logic [1:0] REF_LAST = 2'h3;
    // character timing: ticks per bit and timeout length
    localparam logic [3:0] FRAME_FIXED = 4'h7;
    localparam int unsigned BIT_SHIFT = 4;
    localparam int unsigned TOUT_SHIFT = 6;
    // transmit empty tracker
    typedef enum logic [1:0] {
        TXE_BUSY = 2'b00,
        TXE_WAIT = 2'b01,
        TXE_EMPTY = 2'b10
    } ubg_txe_e;
    // character handed over by the receive shifter
    typedef struct packed {
        logic brk;
        logic frame_err;
        logic par_err;
        logic [7:0] data;
    } ubg_rx_char_s;
endpackage

// *** design/ubg_uart.sv ***
// uart baud generator, fifos and fifo-mode interrupt logic behind an apb slave
`timescale 1ns/1ns
module ubg_uart (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ubg_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // high-speed bit from the configuration space
    input wire logic hs_mode,
    // receive shifter side
    input wire logic rx_push,
    input wire ubg_pkg::ubg_rx_char_s rx_char,
    output logic rx_full_q,
    // transmit shifter side
    output logic tx_valid_q,
    output logic [7:0] tx_data_q,
    input wire logic tx_take,
    input wire logic tx_idle,
    // baud clock
    output logic baud16_q,
    output logic baud_tick_q,
    // interrupt request
    output logic irq_q
);
    import ubg_pkg::*;

    // software registers
    logic [7:0] dll_q, dlh_q, ier_q, lcr_q, scr_q;
    logic fifo_en_q;
    logic [1:0] trig_sel_q;
    // apb response flops
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rdata_c;
    // fifo storage and pointers
    ubg_rx_char_s rx_mem [FIFO_DEPTH];
    logic [7:0] tx_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] rx_wr_q, rx_rd_q, tx_wr_q, tx_rd_q, tx_rd_d;
    logic [CNT_W-1:0] rx_cnt_q, tx_cnt_q, tx_cnt_d;
    // line status error flags {bi, fe, pe, oe}
    logic [3:0] ls_err_q;
    // baud generator state
    logic [15:0] cnt_q, period;
    logic [1:0] ref_q;
    logic in_en;
    // timeout and transmit empty tracking
    logic [9:0] tout_cnt_q, tout_lim;
    logic tout_q;
    ubg_txe_e txe_q;
    logic [8:0] txd_cnt_q, txd_lim;
    logic two_seen_q, thr_int_q;
    logic [CNT_W-1:0] trig;
    logic [3:0] char_bits;
    logic [7:0] iir_c;

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // bus decode; effects happen only at the edge that sees pready high
    wire setup_acc = psel & penable & ~pready_q;
    wire done = psel & penable & pready_q;
    wire [2:0] idx = paddr[IDX_MSB:IDX_LSB];
    wire mapped = (paddr[ADDR_W-1:IDX_MSB+1] == '0) && (paddr[IDX_LSB-1:0] == '0);
    wire wr = ce & done & pwrite & mapped;
    wire rd = ce & done & ~pwrite & mapped;
    wire divisor_access_bit = lcr_q[LCR_DIVISOR_ACCESS_BIT];
    wire wr_dll = wr && idx == IDX_DATA && divisor_access_bit;
    wire wr_dlh = wr && idx == IDX_IER && divisor_access_bit;
    wire wr_thr = wr && idx == IDX_DATA && !divisor_access_bit;
    wire wr_ier = wr && idx == IDX_IER && !divisor_access_bit;
    wire wr_fcr = wr && idx == IDX_IIR;
    wire rd_rbr = rd && idx == IDX_DATA && !divisor_access_bit;
    wire rd_iir = rd && idx == IDX_IIR;
    wire rd_lsr = rd && idx == IDX_LSR;

    // fifo control side effects; toggling the enable flushes both fifos
    wire fen_chg = wr_fcr && (pwdata[FCR_EN] != fifo_en_q);
    wire rx_clr = wr_fcr && (pwdata[FCR_RXCLR] || fen_chg);
    wire tx_clr = wr_fcr && (pwdata[FCR_TXCLR] || fen_chg);
    wire rx_ok = ce & rx_push & ~rx_clr & (rx_cnt_q != FIFO_FULL);
    wire rx_ovr = ce & rx_push & ~rx_clr & (rx_cnt_q == FIFO_FULL);
    wire rx_pop = rd_rbr && rx_cnt_q != '0 && !rx_clr;
    wire tx_ok = wr_thr && tx_cnt_q != FIFO_FULL && !tx_clr;
    wire tx_pop = ce & tx_take & tx_valid_q & ~tx_clr;

    // software register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dll_q <= 8'h00;
            dlh_q <= 8'h00;
            ier_q <= 8'h00;
            lcr_q <= 8'h00;
            scr_q <= 8'h00;
            fifo_en_q <= 1'b0;
            trig_sel_q <= 2'h0;
        end else begin
            if (wr_dll) begin
                dll_q <= pwdata[7:0];
            end
            if (wr_dlh) begin
                dlh_q <= pwdata[7:0];
            end
            // upper nibble of the enable register reads as zero
            if (wr_ier) begin
                ier_q <= {4'h0, pwdata[3:0]};
            end
            if (wr && idx == IDX_LCR) begin
                lcr_q <= pwdata[7:0];
            end
            if (wr && idx == IDX_SCR) begin
                scr_q <= pwdata[7:0];
            end
            if (wr_fcr) begin
                fifo_en_q <= pwdata[FCR_EN];
                trig_sel_q <= pwdata[FCR_TRIG_LSB+1:FCR_TRIG_LSB];
            end
        end
    end

    // read mux, sampled one cycle before the completing edge
    always_comb begin
        rdata_c = 32'h0000_0000;
        if (idx == IDX_DATA && divisor_access_bit) begin
            rdata_c[7:0] = dll_q;
        end else if (idx == IDX_DATA) begin
            rdata_c[7:0] = rx_mem[rx_rd_q].data;
        end else if (idx == IDX_IER && divisor_access_bit) begin
            rdata_c[7:0] = dlh_q;
        end else if (idx == IDX_IER) begin
            rdata_c[7:0] = ier_q;
        end else if (idx == IDX_IIR) begin
            rdata_c[7:0] = iir_c;
        end else if (idx == IDX_LCR) begin
            rdata_c[7:0] = lcr_q;
        end else if (idx == IDX_LSR) begin
            // data ready means fifo not empty
            rdata_c[7:0] = {fifo_en_q & (|ls_err_q[3:1]), tx_cnt_q == '0 && tx_idle,
                            txe_q == TXE_EMPTY, ls_err_q, rx_cnt_q != '0};
        end else if (idx == IDX_SCR) begin
            rdata_c[7:0] = scr_q;
        end
    end

    // apb answer: one wait state, error for addresses outside the block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (ce) begin
            pready_q <= setup_acc;
            if (setup_acc) begin
                pslverr_q <= ~mapped;
                prdata_q <= mapped ? rdata_c : 32'h0000_0000;
            end else begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // receive fifo; an overrun drops the incoming character
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_wr_q <= '0;
            rx_rd_q <= '0;
            rx_cnt_q <= '0;
            rx_full_q <= 1'b0;
        end else if (ce) begin
            if (rx_clr) begin
                rx_wr_q <= '0;
                rx_rd_q <= '0;
                rx_cnt_q <= '0;
                rx_full_q <= 1'b0;
            end else begin
                if (rx_ok) begin
                    rx_mem[rx_wr_q] <= rx_char;
                    rx_wr_q <= rx_wr_q + 1'b1;
                end
                if (rx_pop) begin
                    rx_rd_q <= rx_rd_q + 1'b1;
                end
                rx_cnt_q <= rx_cnt_q + CNT_W'(rx_ok) - CNT_W'(rx_pop);
                rx_full_q <= (rx_cnt_q + CNT_W'(rx_ok) - CNT_W'(rx_pop)) == FIFO_FULL;
            end
        end
    end

    // line status flags; a new error wins over the clearing read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ls_err_q <= 4'h0;
        end else if (ce) begin
            ls_err_q <= (rd_lsr ? 4'h0 : ls_err_q)
                        | {rx_ok & rx_char.brk, rx_ok & rx_char.frame_err,
                           rx_ok & rx_char.par_err, rx_ovr};
        end
    end

    // transmit fifo next state; head data is pre-fetched so the output is a flop
    always_comb begin
        tx_rd_d = tx_rd_q + PTR_W'(tx_pop);
        tx_cnt_d = tx_cnt_q + CNT_W'(tx_ok) - CNT_W'(tx_pop);
        if (tx_clr) begin
            tx_rd_d = '0;
            tx_cnt_d = '0;
        end
    end

    // transmit fifo storage and shifter handshake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_wr_q <= '0;
            tx_rd_q <= '0;
            tx_cnt_q <= '0;
            tx_valid_q <= 1'b0;
            tx_data_q <= 8'h00;
        end else if (ce) begin
            if (tx_ok) begin
                tx_mem[tx_wr_q] <= pwdata[7:0];
            end
            tx_wr_q <= tx_clr ? '0 : tx_wr_q + PTR_W'(tx_ok);
            tx_rd_q <= tx_rd_d;
            tx_cnt_q <= tx_cnt_d;
            tx_valid_q <= tx_cnt_d != '0;
            // a byte written into the slot about to be shown bypasses the array
            tx_data_q <= (tx_ok && tx_wr_q == tx_rd_d) ? pwdata[7:0] : tx_mem[tx_rd_d];
        end
    end

    // effective period and reference rate of the generator
    wire [15:0] div = {dlh_q, dll_q};
    wire hs_x2 = hs_mode && div == DIV_HS_X2;
    wire hs_x4 = hs_mode && div == DIV_HS_X4;
    always_comb begin
        period = (div == '0) ? DIV_ZERO_PERIOD : div;
        // high-speed codes run period one faster
        if (hs_x2 || hs_x4) begin
            period = 16'h0001;
        end
        // input oscillator is pclk over four; pclk over two for the x2 code, pclk itself for the x4 code
        in_en = (ref_q == REF_LAST);
        if (hs_x2) begin
            in_en = ref_q[0];
        end else if (hs_x4) begin
            in_en = 1'b1;
        end
    end

    // reference prescaler feeding the generator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_q <= 2'h0;
        end else if (ce) begin
            ref_q <= ref_q + 2'h1;
        end
    end

    // divisor counter and 16x baud output shaping
    wire div_load = wr_dll | wr_dlh;
    wire [15:0] cnt_nx = (cnt_q == '0) ? period - 16'h0001 : cnt_q - 16'h0001;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 16'h0000;
            baud16_q <= 1'b1;
            baud_tick_q <= 1'b0;
        end else if (ce) begin
            baud_tick_q <= 1'b0;
            if (div_load) begin
                cnt_q <= 16'h0000;
                baud16_q <= 1'b1;
            end else if (in_en) begin
                cnt_q <= cnt_nx;
                baud_tick_q <= cnt_q == '0;
                if (period == 16'h0001) begin
                    baud16_q <= ~baud16_q;
                end else if (period == 16'h0002) begin
                    baud16_q <= cnt_nx[0];
                end else begin
                    baud16_q <= cnt_nx < period - 16'h0002;
                end
            end
        end
    end

    // character length in bits: start, data, parity, stop
    assign char_bits = FRAME_FIXED + {2'b00, lcr_q[1:0]} + {3'b000, lcr_q[LCR_PAR]}
                       + {3'b000, lcr_q[LCR_STOP]};
    assign tout_lim = 10'(char_bits) << TOUT_SHIFT;
    assign txd_lim = 9'(char_bits - 4'h1) << BIT_SHIFT;

    // receive idle timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tout_cnt_q <= 10'h000;
            tout_q <= 1'b0;
        end else if (ce) begin
            if (rx_clr || (rx_cnt_q == '0 && !rx_ok)) begin
                tout_cnt_q <= 10'h000;
                tout_q <= 1'b0;
            end else if (rx_pop) begin
                tout_cnt_q <= 10'h000;
                tout_q <= 1'b0;
            end else if (rx_ok && !tout_q) begin
                tout_cnt_q <= 10'h000;
            end else if (baud_tick_q && !tout_q) begin
                if (tout_cnt_q >= tout_lim - 10'h001) begin
                    tout_q <= 1'b1;
                end else begin
                    tout_cnt_q <= tout_cnt_q + 10'h001;
                end
            end
        end
    end

    // transmit empty tracker: the first empty after a lone byte is held back
    wire txe_enter = (txe_q == TXE_WAIT) && baud_tick_q && txd_cnt_q >= txd_lim;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txe_q <= TXE_EMPTY;
            txd_cnt_q <= 9'h000;
            two_seen_q <= 1'b0;
        end else if (ce) begin
            if (tx_cnt_q >= CNT_W'(2)) begin
                two_seen_q <= 1'b1;
            end
            case (txe_q)
                TXE_BUSY: begin
                    if (tx_cnt_d == '0) begin
                        // delay when fifo never held two
                        txe_q <= (two_seen_q || tx_clr) ? TXE_EMPTY : TXE_WAIT;
                        two_seen_q <= 1'b0;
                        txd_cnt_q <= 9'h000;
                    end
                end
                TXE_WAIT: begin
                    if (tx_cnt_d != '0) begin
                        txe_q <= TXE_BUSY;
                    end else if (txe_enter) begin
                        txe_q <= TXE_EMPTY;
                    end else if (baud_tick_q) begin
                        txd_cnt_q <= txd_cnt_q + 9'h001;
                    end
                end
                TXE_EMPTY: begin
                    if (tx_cnt_d != '0) begin
                        txe_q <= TXE_BUSY;
                    end
                end
                default: begin
                    txe_q <= TXE_EMPTY;
                end
            endcase
        end
    end

    // holding-empty interrupt flag; any set beats a same-cycle clear
    wire thr_en = ier_q[IER_THR];
    wire go_empty = txe_enter || (txe_q == TXE_BUSY && tx_cnt_d == '0 && (two_seen_q || tx_clr));
    wire ier_rise = wr_ier && pwdata[IER_THR] && !thr_en && txe_q == TXE_EMPTY;
    wire thr_set = (thr_en && (go_empty || fen_chg)) || ier_rise;
    wire thr_clr = wr_thr || (rd_iir && prdata_q[3:0] == IIR_THR[3:0])
                   || (wr_ier && !pwdata[IER_THR]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_int_q <= 1'b0;
        end else if (ce) begin
            if (thr_set) begin
                thr_int_q <= 1'b1;
            end else if (thr_clr) begin
                thr_int_q <= 1'b0;
            end
        end
    end

    // trigger level from the fifo control field; without fifo one byte triggers
    always_comb begin
        trig = TRIG_1;
        if (fifo_en_q) begin
            case (trig_sel_q)
                2'h1: trig = TRIG_4;
                2'h2: trig = TRIG_8;
                2'h3: trig = TRIG_14;
                default: trig = TRIG_1;
            endcase
        end
    end

    wire rx_ie = ier_q[IER_RDA];
    wire rda = rx_ie && rx_cnt_q >= trig;
    wire toi = rx_ie && fifo_en_q && tout_q;
    wire lsi = ier_q[IER_LS] && (|ls_err_q);

    // interrupt identification by priority
    always_comb begin
        if (lsi) begin
            iir_c = IIR_LS;
        end else if (toi) begin
            iir_c = IIR_TOUT;
        end else if (rda) begin
            iir_c = IIR_RDA;
        end else if (thr_int_q) begin
            iir_c = IIR_THR;
        end else begin
            iir_c = IIR_NONE;
        end
        if (fifo_en_q) begin
            iir_c = iir_c | IIR_FIFO_ON;
        end
    end

    // registered interrupt request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            irq_q <= ~iir_c[0];
        end
    end
endmodule

// *** dv/ubg_uart_props.sv ***
// port-level checks for the uart baud and fifo interrupt block
`timescale 1ns/1ns
module ubg_uart_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bus side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // line side and status
    input wire logic hs_mode,
    input wire logic rx_push,
    input wire logic rx_full_q,
    input wire logic tx_valid_q,
    input wire logic baud_tick_q,
    input wire logic irq_q
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // answer lasts one cycle, after one wait state
    rdy_one_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    rdy_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    err_rdy_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    // latches are bytes, upper data bits stay clear
    rdata_hi_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data set");
    // the fifo only fills from the shifter
    full_cause_a: assert property ($rose(rx_full_q) |-> $past(rx_push))
        else $error("full without push");
    // reference is pclk/4 outside high-speed mode
    tick_pulse_a: assert property (baud_tick_q && !hs_mode && !pready |=> !baud_tick_q)
        else $error("tick too wide");
    tx_cause_a: assert property ($rose(tx_valid_q) |->
        $past(pready && pwrite) || $past(pready && pwrite, 2))
        else $error("tx head without write");
    // a request only drops after a host access
    irq_drop_a: assert property ($fell(irq_q) |->
        $past(pready) || $past(pready, 2) || $past(pready, 3))
        else $error("irq dropped without access");
endmodule
bind ubg_uart ubg_uart_props ubg_uart_props_inst (.*);

// *** dv/ubg_peer.sv ***
// serial-side stand-in: receive shifter pushes, transmit shifter drains
`timescale 1ns/1ns
module ubg_peer (
    // clock
    input wire logic pclk,
    // receive shifter side
    output logic rx_push,
    output ubg_pkg::ubg_rx_char_s rx_char,
    // transmit shifter side
    input wire logic tx_valid_q,
    input wire logic [7:0] tx_data_q,
    output logic tx_take,
    output logic tx_idle
);
    import ubg_pkg::*;
    logic [1:0] wait_q; // stall count on the head
    logic [7:0] last_q; // last byte drained
    initial begin
        {rx_push, rx_char, tx_take, tx_idle, wait_q, last_q} = '0;
    end
    // one clean character; data scrambled once the pulse ends
    task automatic send(input logic [7:0] d);
        rx_push <= 1'b1;
        rx_char <= '{1'b0, 1'b0, 1'b0, d};
        @(posedge pclk);
        rx_push <= 1'b0;
        rx_char.data <= ~d;
        @(posedge pclk);
    endtask
    // slow drain: hold off three cycles so the fifo sees stalls
    always @(posedge pclk) begin
        wait_q <= (tx_valid_q && !tx_take) ? wait_q + 2'd1 : 2'd0;
        tx_take <= tx_valid_q && !tx_take && wait_q == 2'd2;
        if (tx_take && tx_valid_q) last_q <= tx_data_q;
        tx_idle <= !tx_valid_q;
    end
endmodule

// *** dv/ubg_uart_tb_top.sv ***
// self-checking bench for the baud generator and fifo interrupt block
`timescale 1ns/1ns
module ubg_uart_tb_top;
    import ubg_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hs_mode, rx_push;
    logic rx_full_q, tx_valid_q, tx_take, tx_idle, baud16_q, baud_tick_q, irq_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] tx_data_q;
    ubg_rx_char_s rx_char;
    logic [15:0] dv [4] = '{16'h0005, 16'h0002, 16'h0001, 16'h0000};
    int pv [4] = '{20, 8, 4, 12}; // tick period in pclk cycles
    int lv [4] = '{8, 4, 0, 0}; // low cycles, 0 = not checked
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    ubg_uart ubg_uart_inst (.ce(1'b1), .*);
    ubg_peer ubg_peer_inst (.*);
    initial begin
        pclk = 0;
        forever #10 pclk = ~pclk;
    end
    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            results();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    // one apb transfer, held until pready
    task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, 24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        acc(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e,
                      input logic [7:0] m = 8'hFF, input logic ee = 1'b0);
        logic [31:0] r;
        logic er;
        acc(1'b0, a, 8'h00, r, er);
        chk(r & {24'h0, m}, {24'h0, e});
        chk({31'h0, er}, {31'h0, ee});
    endtask
    task automatic setdiv(input logic [15:0] d);
        wr(12, 8'h80);
        wr(0, d[7:0]);
        wr(4, d[15:8]);
        wr(12, 8'h03);
    endtask
    // one full tick period and its low time
    task automatic per(input int p, input int l);
        int z;
        n = 0;
        z = 0;
        while (baud_tick_q !== 1'b1) @(posedge pclk);
        do begin
            @(posedge pclk);
            n++;
            if (baud16_q === 1'b0) z++;
        end while (baud_tick_q !== 1'b1);
        chk(n, p);
        if (l > 0) chk(z, l);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, hs_mode} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        wr(28, 8'hA5);
        rd(28, 8'hA5);
        rd(16, 8'h00);
        rd(32, 8'h00, 8'hFF, 1'b1);
        $display("map test done");
        setdiv(16'h1234);
        wr(12, 8'h80);
        rd(0, 8'h34);
        rd(4, 8'h12);
        wr(4, 8'h00);
        n = 0;
        while (baud_tick_q !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(n <= 212), 32'h1);
        foreach (dv[i]) begin
            setdiv(dv[i]);
            per(pv[i], lv[i]);
        end
        hs_mode <= 1'b1;
        setdiv(DIV_HS_X2);
        per(2, 0);
        setdiv(DIV_HS_X4);
        per(1, 0);
        setdiv(16'h0001);
        hs_mode <= 1'b0;
        $display("baud test done");
        wr(8, 8'h41);
        wr(4, 8'h00);
        for (int i = 0; i < 4; i++) ubg_peer_inst.send(8'(8'h30 + i));
        chk({31'h0, irq_q}, 32'h0);
        rd(20, 8'h01, 8'h01);
        wr(4, 8'h01);
        rd(8, 8'hC4);
        rd(0, 8'h30);
        rd(8, 8'hC1);
        repeat (600) @(posedge pclk);
        rd(8, 8'hC1);
        repeat (2400) @(posedge pclk);
        rd(8, 8'hCC);
        rd(0, 8'h31);
        rd(8, 8'hC1);
        // fifteen more: fourteen fill the fifo, the last one overruns
        for (int i = 0; i < 15; i++) ubg_peer_inst.send(8'h00);
        chk({31'h0, rx_full_q}, 32'h1);
        wr(4, 8'h05);
        rd(8, 8'hC6);
        rd(20, 8'h03, 8'h03);
        rd(8, 8'hC4);
        $display("receive test done");
        wr(4, 8'h02);
        rd(8, 8'hC2);
        rd(8, 8'hC1);
        wr(8, 8'h00);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq_q}, 32'h1);
        rd(8, 8'h02);
        rd(8, 8'h01);
        wr(0, 8'h5A);
        repeat (12) @(posedge pclk);
        chk({24'h0, ubg_peer_inst.last_q}, 32'h5A);
        rd(20, 8'h00, 8'h20);
        repeat (700) @(posedge pclk);
        rd(20, 8'h20, 8'h20);
        rd(8, 8'h02);
        $display("transmit test done");
        results();
    end
endmodule
